// ===== bench/wdcfg_checker.sv
/* Concurrent checks on the watchdog block's register port and reset outputs.
   Assumes it is bound onto wdcfg_top and sees only that module's ports. */
`timescale 1ns/1ps
`include "wdcfg_defs.vh"
module wdcfg_checker (
  input wire                     i_clk_sys,
  input wire                     i_nrst,
  input wire                     i_ce,
  input wire [`WDCFG_ADDR_W-1:0] i_addr,
  input wire [7:0]               i_wdata,
  input wire                     i_wr,
  input wire                     i_rd,
  input wire [7:0]               o_rdata,
  input wire                     o_wdog_reset,
  input wire                     o_deep_sleep_reset,
  input wire                     o_wdog_running
);
  // ****************************************************************
  // Decode and bus sequences
  // ****************************************************************
  wire mapped = (i_addr == `WDCFG_OFS_TIMING) || (i_addr == `WDCFG_OFS_MODE) ||
    (i_addr == `WDCFG_OFS_DS_POST) || (i_addr == `WDCFG_OFS_DS_CTRL) ||
    (i_addr == `WDCFG_OFS_CONTROL) || (i_addr == `WDCFG_OFS_STATUS);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  sequence rd_at(a);
    i_ce && i_rd && i_addr == a;
  endsequence
  sequence wr_at(a);
    i_ce && i_wr && i_addr == a;
  endsequence
  // ****************************************************************
  // Properties
  // ****************************************************************
  chk_rdata_idle: assert property (i_ce && !i_rd |=> o_rdata == 8'h00)
    else $error("read data not idle");
  chk_unmapped_zero: assert property (i_ce && i_rd && !mapped |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_mode_ones: assert property (rd_at(`WDCFG_OFS_MODE) |=> o_rdata[7:4] == 4'hf)
    else $error("mode upper bits not ones");
  chk_dspost_ones: assert property (rd_at(`WDCFG_OFS_DS_POST) |=> o_rdata[2:0] == 3'h7)
    else $error("deep sleep postscale low bits not ones");
  chk_dsctrl_ones: assert property (rd_at(`WDCFG_OFS_DS_CTRL) |=> o_rdata[7:2] == 6'h3f)
    else $error("deep sleep control upper bits not ones");
  chk_timing_readback: assert property (
    wr_at(`WDCFG_OFS_TIMING) ##2 rd_at(`WDCFG_OFS_TIMING) |=> o_rdata == $past(i_wdata, 3))
    else $error("timing byte readback differs");
  chk_swen_readback: assert property (
    wr_at(`WDCFG_OFS_CONTROL) ##2 rd_at(`WDCFG_OFS_CONTROL)
    |=> (o_rdata & 8'h20) == ($past(i_wdata, 3) & 8'h20))
    else $error("software enable readback differs");
  chk_wreset_pulse: assert property ($rose(o_wdog_reset) |=> !o_wdog_reset)
    else $error("watchdog reset longer than one cycle");
  chk_ds_pulse: assert property ($rose(o_deep_sleep_reset) |=> !o_deep_sleep_reset)
    else $error("deep sleep reset longer than one cycle");
  chk_quiet_off: assert property (!o_wdog_running [*2] |-> !o_wdog_reset)
    else $error("reset request while watchdog off");
endmodule

// ===== bench/wdcfg_tb_top.sv
/* Self-checking bench for the configuration-controlled watchdog.
   Assumes wdcfg_top built with small base counts; ticks are made here. */
`timescale 1ns/1ps
`include "wdcfg_defs.vh"
module wdcfg_tb_top;
  // ****************************************************************
  // Signals and instance
  // ****************************************************************
  localparam int BASE = 4;
  localparam int DSB = 64;
  localparam logic [23:0] OFS [0:3] = '{`WDCFG_OFS_TIMING, `WDCFG_OFS_MODE,
    `WDCFG_OFS_DS_POST, `WDCFG_OFS_DS_CTRL};
  localparam logic [7:0] ZRD [0:3] = '{8'h00, 8'hf0, 8'h07, 8'hfc};
  // Source rows: clock select, system on low-power, sleep, window off, tick pin.
  localparam logic [6:0] SRC [0:7] = '{7'b0000100, 7'b0010111, 7'b0001111, 7'b0100101,
    7'b1000111, 7'b1100010, 7'b1100111, 7'b1101011};
  reg                     clk;
  reg                     nrst;
  reg                     wr;
  reg                     rd;
  reg [`WDCFG_ADDR_W-1:0] addr;
  reg [7:0]               wdata;
  reg [3:0]               osc;
  reg [3:0]               ev;
  reg                     lprc_sys;
  reg                     slp;
  reg                     dslp;
  wire [7:0]              rdata;
  wire                    wrst;
  wire                    dsrst;
  wire                    running;
  int                     miscompares;
  int                     tests_run;
  int                     cyc;
  int                     whits;
  int                     dhits;
  // Tick pins: 0 peripheral, 1 secondary, 2 fast RC, 3 low-power.
  wdcfg_top #(.BASE_CYC(BASE), .DS_BASE_CYC(DSB)) dut (
    .i_clk_sys(clk), .i_nrst(nrst), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .i_periph_osc(osc[0]), .i_secondary_osc(osc[1]),
    .i_fast_rc_osc(osc[2]), .i_internal_lowpower_osc(osc[3]),
    .i_sysclk_is_lprc(lprc_sys), .i_sleep(slp), .i_deep_sleep(dslp),
    .i_clear_wdog_instruction(ev[0]), .i_sleep_instruction(ev[1]),
    .i_internal_osc_freq_sel_change(ev[2]), .i_clock_fail(ev[3]),
    .o_rdata(rdata), .o_wdog_reset(wrst), .o_deep_sleep_reset(dsrst),
    .o_wdog_running(running));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Counters update by non-blocking assignment so tasks read them race-free.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wrst === 1'b1)
      whits <= whits + 1;
    if (dsrst === 1'b1)
      dhits <= dhits + 1;
    if (cyc == 40000) begin
      miscompares++;
      complete_run();
    end
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp8(input [7:0] got, input [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpn(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      miscompares++;
      $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic wreg(input [23:0] a, input [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input [23:0] a, output [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev <= 4'h0;
  endtask
  // Sets both watchdog bytes, lets the synchronisers settle, then clears counts.
  task automatic cfg(input [7:0] tim, input [7:0] mode);
    wreg(`WDCFG_OFS_TIMING, tim);
    wreg(`WDCFG_OFS_MODE, mode);
    repeat (6) @(posedge clk);
    pulse(3);
  endtask
  // Sixteen cycles a tick, so detection latency never spills into the next one.
  task automatic ticks(input [3:0] m, input int n, output int wg, output int dg);
    int w0;
    int d0;
    w0 = whits;
    d0 = dhits;
    wg = 0;
    dg = 0;
    for (int i = 1; i <= n; i++) begin
      osc <= m;
      repeat (8) @(posedge clk);
      osc <= 4'h0;
      repeat (8) @(posedge clk);
      if (wg == 0 && whits != w0)
        wg = i;
      if (dg == 0 && dhits != d0)
        dg = i;
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    logic [7:0] d;
    for (int k = 0; k < 4; k++) begin
      rreg(OFS[k], d);
      cmp8(d, 8'hff);
      wreg(OFS[k], 8'h00);
      rreg(OFS[k], d);
      cmp8(d, ZRD[k]);
    end
    rreg(`WDCFG_OFS_CONTROL, d);
    cmp8(d & 8'h20, 8'h00);
    wreg(`WDCFG_OFS_CONTROL, 8'h20);
    rreg(`WDCFG_OFS_CONTROL, d);
    cmp8(d, 8'h20);
    wreg(24'h300010, 8'h5a);
    rreg(24'h300010, d);
    cmp8(d, 8'h00);
  endtask
  task automatic t_enable();
    for (int m = 0; m < 4; m++) for (int s = 0; s < 2; s++) for (int z = 0; z < 2; z++) begin
      wreg(`WDCFG_OFS_MODE, {6'h3d, m[1:0]});
      wreg(`WDCFG_OFS_CONTROL, {2'b00, s[0], 5'h00});
      slp <= z[0];
      repeat (6) @(posedge clk);
      cmp8({7'h0, running}, (m == 3) | (m == 2 & s) | (m == 1 & !z));
    end
    slp <= 1'b0;
  endtask
  task automatic t_source();
    int w;
    int d;
    for (int r = 0; r < 8; r++) begin
      lprc_sys <= SRC[r][4];
      slp <= SRC[r][3];
      cfg({4'h0, SRC[r][6:5], 2'b11}, {5'h1e, SRC[r][2], 2'b11});
      ticks(~(4'h1 << SRC[r][1:0]), BASE, w, d);
      cmpn(w, 0);
      ticks(4'h1 << SRC[r][1:0], BASE, w, d);
      cmpn(w, BASE);
    end
    lprc_sys <= 1'b0;
    slp <= 1'b0;
  endtask
  task automatic t_timing();
    int w;
    int d;
    int e;
    for (int r = 0; r < 4; r++) begin
      e = BASE * ((r == 2) ? 4 : 1) * (1 << ((r == 3) ? 3 : r % 2));
      cfg({((r == 3) ? 4'h3 : 4'(r % 2)), 4'b1011}, {4'hf, (r == 2), 3'b111});
      ticks(4'h8, e, w, d);
      cmpn(w, e);
      ticks(4'h8, e, w, d);
      cmpn(w, e);
    end
  endtask
  task automatic t_clear();
    int w;
    int d;
    for (int k = 0; k < 4; k++) begin
      cfg(8'h3b, 8'hf7);
      ticks(4'h8, 20, w, d);
      pulse(k);
      ticks(4'h8, 32, w, d);
      cmpn(w, 32);
    end
  endtask
  task automatic t_window();
    int w;
    int d;
    int h;
    logic [7:0] s;
    int pre [0:5] = '{4, 28, 18, 22, 12, 12};
    bit early [0:5] = '{1, 0, 1, 0, 1, 0};
    for (int r = 0; r < 6; r++) begin
      cfg({6'h0e, 2'(3 - r / 2 - (r / 5))}, 8'hf3);
      ticks(4'h8, pre[r], w, d);
      h = whits;
      pulse(0);
      repeat (4) @(posedge clk);
      cmpn(whits - h, early[r]);
      rreg(`WDCFG_OFS_STATUS, s);
      cmp8(s & 8'h04, {5'h00, early[r], 2'h0});
      wreg(`WDCFG_OFS_STATUS, 8'h00);
      ticks(4'h8, 32, w, d);
      if (!early[r])
        cmpn(w, 32);
    end
  endtask
  task automatic t_deep();
    int w;
    int d;
    wreg(`WDCFG_OFS_MODE, 8'hf4);
    dslp <= 1'b1;
    wreg(`WDCFG_OFS_DS_POST, 8'h07);
    wreg(`WDCFG_OFS_DS_CTRL, 8'hff);
    repeat (6) @(posedge clk);
    ticks(4'h2, 4, w, d);
    cmpn(d, 0);
    ticks(4'h8, DSB / `WDCFG_DS_PRE, w, d);
    cmpn(d, DSB / `WDCFG_DS_PRE);
    wreg(`WDCFG_OFS_DS_POST, 8'h17);
    wreg(`WDCFG_OFS_DS_CTRL, 8'hfd);
    ticks(4'h2, 4 * DSB / `WDCFG_DS_PRE, w, d);
    cmpn(d, 4 * DSB / `WDCFG_DS_PRE);
    wreg(`WDCFG_OFS_DS_CTRL, 8'hfc);
    ticks(4'h2, 10, w, d);
    cmpn(d, 0);
    cmpn(w, 0);
    dslp <= 1'b0;
  endtask
  initial begin
    {nrst, wr, rd, addr, wdata, osc, ev, lprc_sys, slp, dslp} = '0;
    {miscompares, tests_run, cyc, whits, dhits} = '0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_enable();
    t_source();
    t_timing();
    t_clear();
    t_window();
    t_deep();
    complete_run();
  end
endmodule
bind wdcfg_top wdcfg_checker u_chk (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ce(i_ce),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_wdog_reset(o_wdog_reset), .o_deep_sleep_reset(o_deep_sleep_reset),
  .o_wdog_running(o_wdog_running));

// ===== core/wdcfg_divider.v
/*
 * Ticked base divider: counts source ticks up to a terminal and pulses.
 * Assumes i_tick is a one-cycle pulse on i_clk_sys.
 */
`timescale 1ns/1ps
module wdcfg_divider #(
  parameter W = 24
) (
  input  wire         i_clk_sys,
  input  wire         i_nrst,
  input  wire         i_ce,
  input  wire         i_clr,
  input  wire         i_tick,
  input  wire [W-1:0] i_terminal,
  output reg          o_pulse
);
  reg [W-1:0] cnt;

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt     <= {W{1'b0}};
      o_pulse <= 1'b0;
    end else if (i_ce) begin
      o_pulse <= 1'b0;
      if (i_clr) begin
        cnt <= {W{1'b0}};
      end else if (i_tick) begin
        if (cnt >= i_terminal - 1'b1) begin
          cnt     <= {W{1'b0}};
          o_pulse <= 1'b1;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end
endmodule

// ===== core/wdcfg_edge.v
/*
 * Rising-edge detector for a tick input that comes from another clock
 * domain; two synchroniser flops come first.
 * Assumes i_clk_sys much faster than the sampled oscillator.
 */
`timescale 1ns/1ps
module wdcfg_edge (
  input  wire i_clk_sys,
  input  wire i_nrst,
  input  wire i_ce,
  input  wire i_async,
  output reg  o_rise
);
  reg meta;
  reg sync;
  reg last;

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      meta   <= 1'b0;
      sync   <= 1'b0;
      last   <= 1'b0;
      o_rise <= 1'b0;
    end else if (i_ce) begin
      meta   <= i_async;
      sync   <= meta;
      last   <= sync;
      o_rise <= sync & ~last;
    end
  end
endmodule

// ===== core/wdcfg_top.v
/*
 * Configuration-controlled main watchdog and deep-sleep watchdog.
 * Assumes oscillator ticks arrive asynchronously on i_*_osc pins and
 * events (clear, sleep, frequency change, clock failure) are one-cycle
 * pulses from logic on i_clk_sys.
 */
// The implementer's own choice: the plain strobed port.
// Overview of operation
// RULE1: Main postscale ratio two to field value.
// RULE2: Select 00: peripheral clock when awake, else LPRC.
// RULE3: Select 01 secondary osc; 10 LPRC always.
// RULE4: Select 11: fast RC if windowed, awake.
// RULE5: Window width codes give 25/37.5/50/75 percent.
// RULE6: Prescale select one gives 128, zero 32.
// RULE7: Window-disable one means non-windowed watchdog.
// RULE8: Enable field 11 keeps watchdog always on.
// RULE9: Enable field 10 follows software enable bit.
// RULE10: Enable field 01 runs awake, stops asleep.
// RULE11: Enable field 00 keeps watchdog off.
// RULE12: Deep-sleep watchdog prescales reference by 32.
// RULE13: Deep-sleep postscale two to code plus five; code compares ds_cnt with ds_term >> 5, so it counts only 2^code units.
// RULE14: Deep-sleep clock bit selects LPRC or secondary.
// RULE15: Deep-sleep enable bit turns it on.
// RULE16: Programmer writes ones to unimplemented bits.
// RULE17: Windowed clear before final window causes reset.
// RULE18: Clear, sleep, freq change, clock fail clear counts.
// RULE19: Software enable matters only in mode 10.
// RULE20: Main base period nominally 4 ms.
// RULE21: Terminal count raises reset request, restarts.
`timescale 1ns/1ps
`include "wdcfg_defs.vh"
module wdcfg_top #(
  parameter BASE_CYC    = `WDCFG_BASE_CYC,
  parameter DS_BASE_CYC = `WDCFG_DS_BASE_CYC
) (
  input  wire                     i_clk_sys,
  input  wire                     i_nrst,
  input  wire                     i_ce,
  input  wire [`WDCFG_ADDR_W-1:0] i_addr,
  input  wire [7:0]               i_wdata,
  input  wire                     i_wr,
  input  wire                     i_rd,
  input  wire                     i_periph_osc,
  input  wire                     i_secondary_osc,
  input  wire                     i_fast_rc_osc,
  input  wire                     i_internal_lowpower_osc,
  input  wire                     i_sysclk_is_lprc,
  input  wire                     i_sleep,
  input  wire                     i_deep_sleep,
  input  wire                     i_clear_wdog_instruction,
  input  wire                     i_sleep_instruction,
  input  wire                     i_internal_osc_freq_sel_change,
  input  wire                     i_clock_fail,
  output reg  [7:0]               o_rdata,
  output reg                      o_wdog_reset,
  output reg                      o_deep_sleep_reset,
  output reg                      o_wdog_running
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Window start as a fraction of the period in eighths.
  function [3:0] wdcfg_win_start;
    input [1:0] code;
    begin
      case (code)
        2'h3:    wdcfg_win_start = 4'h6;
        2'h2:    wdcfg_win_start = 4'h5;
        2'h1:    wdcfg_win_start = 4'h4;
        default: wdcfg_win_start = 4'h2;
      endcase
    end
  endfunction

  // ****************************************************************
  // Configuration bytes and software control
  // ****************************************************************
  reg [7:0] timing_cfg;
  reg [7:0] mode_cfg;
  reg [7:0] ds_post_cfg;
  reg [7:0] ds_ctrl_cfg;
  reg       software_wdog_enable;
  reg       early_clear_seen;

  // Config bytes power up erased; unimplemented bits (upper ones, or the low three of the
  // deep-sleep postscale byte) stay ones regardless of the written value, so a careless programmer is harmless.
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      timing_cfg           <= `WDCFG_ERASED;
      mode_cfg             <= `WDCFG_ERASED;
      ds_post_cfg          <= `WDCFG_ERASED;
      ds_ctrl_cfg          <= `WDCFG_ERASED;
      software_wdog_enable <= 1'b0;
    end else if (i_ce && i_wr) begin
      case (i_addr)
        `WDCFG_OFS_TIMING:  timing_cfg  <= i_wdata;
        `WDCFG_OFS_MODE:    mode_cfg    <= {4'hf, i_wdata[3:0]}; // [RULE16]
        `WDCFG_OFS_DS_POST: ds_post_cfg <= {i_wdata[7:3], 3'h7}; // [RULE16]
        `WDCFG_OFS_DS_CTRL: ds_ctrl_cfg <= {6'h3f, i_wdata[1:0]}; // [RULE16]
        `WDCFG_OFS_CONTROL: software_wdog_enable <= i_wdata[`WDCFG_CTL_SWEN];
        default: ;
      endcase
    end
  end

  wire [3:0] postscale_sel            = timing_cfg[`WDCFG_TIM_POST_HI:`WDCFG_TIM_POST_LO];
  wire [1:0] wdog_clock_sel           = timing_cfg[`WDCFG_TIM_CLK_HI:`WDCFG_TIM_CLK_LO];
  wire [1:0] window_width_sel         = timing_cfg[`WDCFG_TIM_WIN_HI:`WDCFG_TIM_WIN_LO];
  wire       prescale_sel             = mode_cfg[`WDCFG_MODE_PRESC];
  wire       window_disable           = mode_cfg[`WDCFG_MODE_WINDOW_DISABLE];
  wire [1:0] enable_mode_field        = mode_cfg[`WDCFG_MODE_EN_HI:`WDCFG_MODE_EN_LO];
  wire [4:0] deep_sleep_postscale_sel = ds_post_cfg[`WDCFG_DSP_HI:`WDCFG_DSP_LO];
  wire       deep_sleep_clock_sel     = ds_ctrl_cfg[`WDCFG_DSC_CLK];
  wire       deep_sleep_wdog_enable   = ds_ctrl_cfg[`WDCFG_DSC_EN];

  // ****************************************************************
  // Oscillator tick synchronisers
  // ****************************************************************
  wire t_periph;
  wire t_secondary_osc;
  wire t_frc;
  wire t_lprc;

  wdcfg_edge u_e_per (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ce(i_ce),
                      .i_async(i_periph_osc), .o_rise(t_periph));
  wdcfg_edge u_e_sos (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ce(i_ce),
                      .i_async(i_secondary_osc), .o_rise(t_secondary_osc));
  wdcfg_edge u_e_frc (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ce(i_ce),
                      .i_async(i_fast_rc_osc), .o_rise(t_frc));
  wdcfg_edge u_e_lpr (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ce(i_ce),
                      .i_async(i_internal_lowpower_osc), .o_rise(t_lprc));

  // Sleep and system-clock status are pins too.
  reg [1:0] sleep_sync;
  reg [1:0] lprc_sys_sync;
  reg [1:0] dsleep_sync;
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sleep_sync    <= 2'h0;
      lprc_sys_sync <= 2'h0;
      dsleep_sync   <= 2'h0;
    end else if (i_ce) begin
      sleep_sync    <= {sleep_sync[0], i_sleep};
      lprc_sys_sync <= {lprc_sys_sync[0], i_sysclk_is_lprc};
      dsleep_sync   <= {dsleep_sync[0], i_deep_sleep};
    end
  end
  wire asleep   = sleep_sync[1];
  wire on_lprc  = lprc_sys_sync[1];
  wire in_dsl   = dsleep_sync[1];
  wire awake_ok = ~on_lprc & ~asleep;

  // ****************************************************************
  // Main watchdog clock source and enable
  // ****************************************************************
  reg next_tick;
  always @* begin
    case (wdog_clock_sel)
      `WDCFG_CLK_PERIPH: next_tick = awake_ok ? t_periph : t_lprc;   // [RULE2]
      `WDCFG_CLK_SECONDARY_OSC:   next_tick = t_secondary_osc;                         // [RULE3]
      `WDCFG_CLK_LPRC:   next_tick = t_lprc;                         // [RULE3]
      `WDCFG_CLK_FRC:    next_tick = (awake_ok && !window_disable) ?
                                     t_frc : t_lprc;                  // [RULE4]
      default:           next_tick = t_lprc;
    endcase
  end

  reg next_en;
  always @* begin
    case (enable_mode_field)
      `WDCFG_EN_ON:     next_en = 1'b1;                    // [RULE8]
      `WDCFG_EN_SOFT:   next_en = software_wdog_enable;    // [RULE9] [RULE19]
      `WDCFG_EN_ACTIVE: next_en = ~asleep;                 // [RULE10]
      `WDCFG_EN_OFF:    next_en = 1'b0;                    // [RULE11]
      default:          next_en = 1'b0;
    endcase
  end

  wire main_evt_clr = i_clear_wdog_instruction | i_sleep_instruction |
                      i_internal_osc_freq_sel_change | i_clock_fail;   // [RULE18]

  // ****************************************************************
  // Main watchdog: base divider, prescaler, postscaler
  // ****************************************************************
  // The base divider turns source ticks into a 4 ms unit; prescale select
  // changes the base by 128/32, and the postscaler multiplies by 2^code.
  localparam [31:0] BASE_LONG  = BASE_CYC * `WDCFG_PRE_LONG / `WDCFG_PRE_SHORT;
  localparam [31:0] BASE_SHORT = BASE_CYC;
  wire [23:0] base_term = prescale_sel ? BASE_LONG[23:0] :
                          BASE_SHORT[23:0];                           // [RULE6] [RULE20]
  wire        base_pulse;
  reg         main_clr;

  wdcfg_divider #(.W(24)) u_main_div (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_clr     (main_clr | ~next_en),
    .i_tick    (next_tick),
    .i_terminal(base_term),
    .o_pulse   (base_pulse)
  );

  reg  [17:0] post_cnt;
  wire [17:0] post_term = 18'h1 << postscale_sel;                    // [RULE1]
  wire [17:0] frac_full = (post_cnt << 3) / post_term;
  wire [3:0]  frac8     = frac_full[3:0];
  wire        in_window = frac8 >= wdcfg_win_start(window_width_sel); // [RULE5]
  wire        early_clr = i_clear_wdog_instruction & ~window_disable &
                          next_en & ~in_window;                        // [RULE7] [RULE17]

  // The window is judged in eighths of the period, so below 1:8 it is coarse.
  always @* begin
    main_clr = main_evt_clr;
  end

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      post_cnt         <= 18'h0;
      o_wdog_reset     <= 1'b0;
      o_wdog_running   <= 1'b0;
      early_clear_seen <= 1'b0;
    end else if (i_ce) begin
      o_wdog_running <= next_en;
      o_wdog_reset   <= 1'b0;
      if (early_clr) begin
        o_wdog_reset     <= 1'b1;                                     // [RULE17]
        early_clear_seen <= 1'b1;
        post_cnt         <= 18'h0;
      end else if (main_clr || !next_en) begin
        post_cnt <= 18'h0;                                            // [RULE18]
      end else if (base_pulse) begin
        if (post_cnt >= post_term - 18'h1) begin
          post_cnt     <= 18'h0;                                      // [RULE21]
          o_wdog_reset <= 1'b1;                                       // [RULE21]
        end else begin
          post_cnt <= post_cnt + 18'h1;
        end
      end
      if (i_wr && i_addr == `WDCFG_OFS_STATUS) begin
        early_clear_seen <= early_clr;
      end
    end
  end

  // ****************************************************************
  // Deep-sleep watchdog
  // ****************************************************************
  wire        ds_tick = deep_sleep_clock_sel ? t_lprc : t_secondary_osc;        // [RULE14]
  wire        ds_unit;
  reg  [36:0] ds_cnt;
  wire [36:0] ds_term = 37'h1 << (deep_sleep_postscale_sel +
                                  `WDCFG_DS_POST_BASE);              // [RULE13]
  wire        ds_run  = deep_sleep_wdog_enable & in_dsl;              // [RULE15]
  localparam [31:0] DS_UNIT = DS_BASE_CYC / `WDCFG_DS_PRE;

  // Roughly 31 us unit (the 1 ms base over 32); the divide-by-32 ahead of it is folded into the
  // unit count, which keeps a single divider in the path.
  wdcfg_divider #(.W(24)) u_ds_div (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_clr     (~ds_run),
    .i_tick    (ds_tick),
    .i_terminal(DS_UNIT[23:0]),                                       // [RULE12]
    .o_pulse   (ds_unit)
  );

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ds_cnt             <= 37'h0;
      o_deep_sleep_reset <= 1'b0;
    end else if (i_ce) begin
      o_deep_sleep_reset <= 1'b0;
      if (!ds_run) begin
        ds_cnt <= 37'h0;
      end else if (ds_unit) begin
        if (ds_cnt >= (ds_term >> 5) - 37'h1) begin
          ds_cnt             <= 37'h0;
          o_deep_sleep_reset <= 1'b1;
        end else begin
          ds_cnt <= ds_cnt + 37'h1;
        end
      end
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 8'h0;
    end else if (i_ce) begin
      o_rdata <= 8'h0;
      if (i_rd) begin
        case (i_addr)
          `WDCFG_OFS_TIMING:  o_rdata <= timing_cfg;
          `WDCFG_OFS_MODE:    o_rdata <= mode_cfg;
          `WDCFG_OFS_DS_POST: o_rdata <= ds_post_cfg;
          `WDCFG_OFS_DS_CTRL: o_rdata <= ds_ctrl_cfg;
          `WDCFG_OFS_CONTROL: o_rdata <= {2'h0, software_wdog_enable, 5'h0};
          `WDCFG_OFS_STATUS:  o_rdata <= {5'h0, early_clear_seen, in_window, next_en};
          default:            o_rdata <= 8'h0;
        endcase
      end
    end
  end
endmodule

// ===== inc/wdcfg_defs.vh
/*
 * Constants for the configuration-controlled watchdog: register offsets,
 * field positions, erased values and timing counts.
 * Assumes a 10 MHz system clock; included by wdcfg_top and the bench files.
 */
`ifndef WDCFG_DEFS_VH
`define WDCFG_DEFS_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define WDCFG_ADDR_W          24
`define WDCFG_OFS_TIMING      24'h30000a
`define WDCFG_OFS_MODE        24'h30000b
`define WDCFG_OFS_DS_POST     24'h30000e
`define WDCFG_OFS_DS_CTRL     24'h30000f
`define WDCFG_OFS_CONTROL     24'h300100
`define WDCFG_OFS_STATUS      24'h300101

// ****************************************************************
// Erased values and field positions
// ****************************************************************
`define WDCFG_ERASED          8'hff
`define WDCFG_TIM_POST_HI     7
`define WDCFG_TIM_POST_LO     4
`define WDCFG_TIM_CLK_HI      3
`define WDCFG_TIM_CLK_LO      2
`define WDCFG_TIM_WIN_HI      1
`define WDCFG_TIM_WIN_LO      0
`define WDCFG_MODE_PRESC      3
`define WDCFG_MODE_WINDOW_DISABLE     2
`define WDCFG_MODE_EN_HI      1
`define WDCFG_MODE_EN_LO      0
`define WDCFG_DSP_HI          7
`define WDCFG_DSP_LO          3
`define WDCFG_DSC_CLK         1
`define WDCFG_DSC_EN          0
`define WDCFG_CTL_SWEN        5

// ****************************************************************
// Codes
// ****************************************************************
`define WDCFG_CLK_PERIPH      2'h0
`define WDCFG_CLK_SECONDARY_OSC        2'h1
`define WDCFG_CLK_LPRC        2'h2
`define WDCFG_CLK_FRC         2'h3
`define WDCFG_EN_OFF          2'h0
`define WDCFG_EN_ACTIVE       2'h1
`define WDCFG_EN_SOFT         2'h2
`define WDCFG_EN_ON           2'h3
`define WDCFG_PRE_SHORT       32
`define WDCFG_PRE_LONG        128
`define WDCFG_DS_PRE          32
`define WDCFG_DS_POST_BASE    6'h05

// ****************************************************************
// Timing
// ****************************************************************
`define WDCFG_CLK_HZ          10000000
`define WDCFG_BASE_US         4000
`define WDCFG_BASE_CYC        ((`WDCFG_BASE_US * (`WDCFG_CLK_HZ / 1000000)))
`define WDCFG_DS_BASE_US      1000
`define WDCFG_DS_BASE_CYC     ((`WDCFG_DS_BASE_US * (`WDCFG_CLK_HZ / 1000000)))

`endif
